// ---- rtl/vpim_pkg.sv ----
package vpim_pkg;

    // ****************************************
    // vector space
    // ****************************************
    localparam int NUM_VEC = 64;
    localparam int VEC_W = 6;
    localparam int ADDR_W = 21;
    localparam int RANK_W = 3;
    localparam int APB_AW = 12;
    // entries 0/1 overlay reset and watchdog reset; the rest are holes
    localparam logic [63:0] RESV_MASK = 64'h001E_00F0_C000_4003;
    localparam logic [VEC_W-1:0] VEC_LOWEST = 6'h3F;

    // rank 0 means nothing pending; rank = level + 2 otherwise
    localparam logic [RANK_W-1:0] RANK_NONE = 3'h0;
    localparam logic [RANK_W-1:0] RANK_LP = 3'h1;
    localparam logic [RANK_W-1:0] RANK_OFS = 3'h2;
    localparam logic [1:0] HI_RST_LVL = 2'h1;
    localparam logic [1:0] LO_RST_LVL = 2'h0;
    localparam logic [1:0] LVL_MAX = 2'h3;
    localparam logic [1:0] LVL_MIN = 2'h0;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
    localparam logic [APB_AW-1:0] VBA_OFS = 12'h004;
    localparam logic [APB_AW-1:0] STAT_OFS = 12'h008;
    localparam logic [APB_AW-1:0] MASK_OFS = 12'h00C;
    localparam logic [APB_AW-1:0] ACTIVE_OFS = 12'h010;
    localparam logic [APB_AW-1:0] LVL_TBL_OFS = 12'h100;
    localparam int CTRL_EN_BIT = 0;
    localparam int ST_TAKEN = 0;
    localparam int ST_REJECT = 1;
    localparam int ST_NEW = 2;
    localparam int ST_W = 3;
    localparam int ACT_VALID_BIT = 31;
    localparam int ACT_LVL_LSB = 8;
    localparam logic [ADDR_W-1:0] VBA_RST = 21'h0;
    localparam logic CTRL_EN_RST = 1'b0;

    typedef enum logic [2:0] {CLS_RESV, CLS_FIX, CLS_HI, CLS_LO, CLS_LP}
        class_e;

    function automatic class_e vec_class(input logic [VEC_W-1:0] v);
        if (RESV_MASK[v])
            return CLS_RESV;
        else if (v <= 6'h05 || (v >= 6'h0B && v <= 6'h0D))
            return CLS_FIX;
        else if (v <= 6'h0A || v == 6'h0F || v == 6'h10)
            return CLS_HI;
        else if (v == VEC_LOWEST)
            return CLS_LP;
        return CLS_LO;
    endfunction : vec_class

    function automatic logic [1:0] fixed_level(input logic [VEC_W-1:0] v);
        unique case (v)
            6'h0B: return 2'h2;
            6'h0C: return 2'h1;
            6'h0D: return 2'h0;
            default: return 2'h3;
        endcase
    endfunction : fixed_level

    function automatic logic [RANK_W-1:0] lvl_to_rank(input logic [1:0] l);
        return RANK_W'({1'b0, l} + RANK_OFS);
    endfunction : lvl_to_rank

endpackage : vpim_pkg

// ---- rtl/lvl_if.sv ----
interface lvl_if;
    import vpim_pkg::*;
    logic wr_en;
    logic [VEC_W-1:0] wr_vec;
    logic [1:0] wr_lvl;
    logic wr_reject;
    logic [NUM_VEC-1:0][RANK_W-1:0] rank;
    modport store (input wr_en, wr_vec, wr_lvl, output wr_reject, rank);
    modport ctl (output wr_en, wr_vec, wr_lvl, input wr_reject, rank);
    modport arb (input rank);
endinterface : lvl_if

// ---- rtl/prio_level_store.sv ----
module prio_level_store (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // level table
    lvl_if.store lv
);
    import vpim_pkg::*;

    logic [1:0] levels_r [NUM_VEC];
    logic wr_ok;
    logic reject_r;

    // refused writes leave the old level in place
    always_comb
    begin
        unique case (vec_class(lv.wr_vec))
            CLS_HI: wr_ok = (lv.wr_lvl != LVL_MIN);
            CLS_LO: wr_ok = (lv.wr_lvl != LVL_MAX);
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < NUM_VEC; i++)
                levels_r[i] <= (vec_class(VEC_W'(i)) == CLS_HI) ?
                               HI_RST_LVL : LO_RST_LVL;
        end
        else if (lv.wr_en && wr_ok)
            levels_r[lv.wr_vec] <= lv.wr_lvl;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            reject_r <= 1'b0;
        else
            reject_r <= lv.wr_en && !wr_ok;
    end

    assign lv.wr_reject = reject_r;

    always_comb
    begin
        for (int v = 0; v < NUM_VEC; v++)
        begin
            unique case (vec_class(VEC_W'(v)))
                CLS_RESV: lv.rank[v] = RANK_NONE;
                CLS_FIX: lv.rank[v] = lvl_to_rank(fixed_level(VEC_W'(v)));
                CLS_LP: lv.rank[v] = RANK_LP;
                default: lv.rank[v] = lvl_to_rank(levels_r[v]);
            endcase
        end
    end

endmodule : prio_level_store

// ---- rtl/prio_arbiter.sv ----
module prio_arbiter (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // requests and control
    input wire logic [vpim_pkg::NUM_VEC-1:0] req,
    input wire logic en,
    input wire logic [vpim_pkg::ADDR_W-1:0] vector_table_base,
    lvl_if.arb lv,
    // winner
    output logic win_valid,
    output logic [vpim_pkg::VEC_W-1:0] win_vec,
    output logic [vpim_pkg::RANK_W-1:0] win_level,
    output logic [vpim_pkg::ADDR_W-1:0] win_addr
);
    import vpim_pkg::*;

    logic [RANK_W-1:0] best;
    logic [VEC_W-1:0] bvec;

    // downward scan with >= lets the smaller vector win a tie
    always_comb
    begin
        best = RANK_NONE;
        bvec = '0;
        for (int v = NUM_VEC - 1; v >= 0; v--)
        begin
            if (req[v] && !RESV_MASK[v] && lv.rank[v] != RANK_NONE &&
                lv.rank[v] >= best)
            begin
                best = lv.rank[v];
                bvec = VEC_W'(v);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            win_valid <= 1'b0;
            win_vec <= '0;
            win_level <= '0;
            win_addr <= VBA_RST;
        end
        else
        begin
            win_valid <= en && (best != RANK_NONE);
            win_vec <= bvec;
            win_level <= RANK_W'(best - RANK_OFS);
            // two words per entry
            win_addr <= ADDR_W'(vector_table_base + {bvec, 1'b0});
        end
    end

endmodule : prio_arbiter

// ---- rtl/vectored_priority_interrupt_map.sv ----
// Notes on behaviour
// - higher level always served before lower
// - equal level: smallest vector number wins
// - programmable sources arbitrate at assigned level
// - vector table placed by programmable base
// - base is zero after reset
// - entries 0 and 1 never raised
// - two words per entry, 21-bit targets
// - vectors 2 to 5 fixed level 3
// - debug vectors 6-10 accept levels 1-3
// - vectors 15, 16 accept levels 1-3
// - flash vectors 17-19 accept levels 0-2
// - vectors 20-62 accept levels 0-2, except holes, which refuse every write
// - vector 63 level -1, taken last
module vectored_priority_interrupt_map #(
    parameter int PADDR_W = vpim_pkg::APB_AW
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // apb slave
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt sources, one level per vector
    input wire logic [vpim_pkg::NUM_VEC-1:0] irq_req,
    // processor core
    output logic core_irq_valid,
    output logic [vpim_pkg::VEC_W-1:0] core_irq_vector,
    output logic [vpim_pkg::RANK_W-1:0] core_irq_level,
    output logic [vpim_pkg::ADDR_W-1:0] core_vector_addr,
    input wire logic core_irq_ack,
    // controller event interrupt
    output logic irq
);
    import vpim_pkg::*;

    // ****************************************
    // elaboration checks
    // ****************************************
    if (PADDR_W < 9 || PADDR_W > APB_AW)
        $error("PADDR_W must lie between 9 and 12");

    // ****************************************
    // state
    // ****************************************
    lvl_if lv ();

    logic ctrl_en_r;
    logic [ADDR_W-1:0] vba_r;
    logic [ST_W-1:0] sts_r;
    logic [ST_W-1:0] sts_nxt;
    logic [ST_W-1:0] mask_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic valid_d_r;
    logic [ST_W-1:0] sts_set;
    logic setup;
    logic access;
    logic wr_acc;
    logic [APB_AW-1:0] addr;

    assign addr = APB_AW'(paddr);
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr_acc = access && pwrite;

    function automatic logic is_tbl(input logic [APB_AW-1:0] a);
        return (a[APB_AW-1:8] == LVL_TBL_OFS[APB_AW-1:8]) &&
               (a[1:0] == 2'b00);
    endfunction : is_tbl

    function automatic logic is_mapped(input logic [APB_AW-1:0] a);
        return is_tbl(a) || a == CTRL_OFS || a == VBA_OFS ||
               a == STAT_OFS || a == MASK_OFS || a == ACTIVE_OFS;
    endfunction : is_mapped

    // ****************************************
    // level table and arbiter
    // ****************************************
    prio_level_store u_store (
        .clk(clk),
        .resetn(resetn),
        .lv(lv.store)
    );

    // entries 0, 1 and holes are cut here and again in the arbiter
    prio_arbiter u_arb (
        .clk(clk),
        .resetn(resetn),
        .req(irq_req & ~RESV_MASK),
        .en(ctrl_en_r),
        .vector_table_base(vba_r),
        .lv(lv.arb),
        .win_valid(core_irq_valid),
        .win_vec(core_irq_vector),
        .win_level(core_irq_level),
        .win_addr(core_vector_addr)
    );

    // table writes take effect at the access edge
    assign lv.wr_en = wr_acc && is_tbl(addr);
    assign lv.wr_vec = addr[VEC_W+1:2];
    assign lv.wr_lvl = pwdata[1:0];

    // ****************************************
    // apb control registers
    // ****************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ctrl_en_r <= CTRL_EN_RST;
        else if (wr_acc && addr == CTRL_OFS)
            ctrl_en_r <= pwdata[CTRL_EN_BIT];
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            vba_r <= VBA_RST;
        else if (wr_acc && addr == VBA_OFS)
            vba_r <= pwdata[ADDR_W-1:0];
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            mask_r <= '0;
        else if (wr_acc && addr == MASK_OFS)
            mask_r <= pwdata[ST_W-1:0];
    end

    // ****************************************
    // event status
    // ****************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            valid_d_r <= 1'b0;
        else
            valid_d_r <= core_irq_valid;
    end

    always_comb
    begin
        sts_set = '0;
        sts_set[ST_TAKEN] = core_irq_ack && core_irq_valid;
        sts_set[ST_REJECT] = lv.wr_reject;
        sts_set[ST_NEW] = core_irq_valid && !valid_d_r;
        sts_nxt = sts_r;
        // write-one-to-clear first so a same-cycle event survives
        if (wr_acc && addr == STAT_OFS)
            sts_nxt = sts_nxt & ~pwdata[ST_W-1:0];
        sts_nxt = sts_nxt | sts_set;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            sts_r <= '0;
        else
            sts_r <= sts_nxt;
    end

    assign irq = |(sts_r & mask_r);

    // ****************************************
    // read path
    // ****************************************
    // data captured in setup so prdata is a flop; zero wait states
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end
        else if (setup)
        begin
            pslverr_r <= !is_mapped(addr);
            prdata_r <= '0;
            if (is_tbl(addr))
                prdata_r <= {29'h0,
                    RANK_W'(lv.rank[addr[VEC_W+1:2]] - RANK_OFS)};
            else
            begin
                unique case (addr)
                    CTRL_OFS: prdata_r[CTRL_EN_BIT] <= ctrl_en_r;
                    VBA_OFS: prdata_r[ADDR_W-1:0] <= vba_r;
                    STAT_OFS: prdata_r[ST_W-1:0] <= sts_r;
                    MASK_OFS: prdata_r[ST_W-1:0] <= mask_r;
                    ACTIVE_OFS:
                    begin
                        prdata_r[ACT_VALID_BIT] <= core_irq_valid;
                        prdata_r[ACT_LVL_LSB+RANK_W-1:ACT_LVL_LSB] <=
                            core_irq_level;
                        prdata_r[VEC_W-1:0] <= core_irq_vector;
                    end
                    default: prdata_r <= '0;
                endcase
            end
        end
    end

    assign prdata = prdata_r;
    assign pslverr = pslverr_r && access;
    assign pready = access;

    // ****************************************
    // checks
    // ****************************************
    logic first_r;
    logic [NUM_VEC-1:0] live;
    logic [RANK_W-1:0] max_rank;
    logic [VEC_W-1:0] first_max_vec;
    logic found;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            first_r <= 1'b1;
        else
            first_r <= 1'b0;
    end

    // independent upward scan to cross-check the arbiter
    always_comb
    begin
        live = irq_req & ~RESV_MASK;
        max_rank = RANK_NONE;
        first_max_vec = '0;
        found = 1'b0;
        for (int v = 0; v < NUM_VEC; v++)
            if (live[v] && lv.rank[v] > max_rank)
                max_rank = lv.rank[v];
        for (int v = 0; v < NUM_VEC; v++)
        begin
            if (!found && live[v] && max_rank != RANK_NONE &&
                lv.rank[v] == max_rank)
            begin
                first_max_vec = VEC_W'(v);
                found = 1'b1;
            end
        end
    end

    chk_level_order: assert property (
        @(posedge clk) disable iff (!resetn)
        (ctrl_en_r && max_rank != RANK_NONE) |=>
            core_irq_valid &&
            core_irq_level == RANK_W'($past(max_rank) - RANK_OFS))
        else $error("winner is not at the highest pending level");

    chk_tie_lowest: assert property (
        @(posedge clk) disable iff (!resetn)
        (ctrl_en_r && max_rank != RANK_NONE) |=>
            core_irq_vector == $past(first_max_vec))
        else $error("tie not broken toward smallest vector");

    chk_vector_addr: assert property (
        @(posedge clk) disable iff (!resetn)
        core_irq_valid |->
            core_vector_addr ==
            ADDR_W'($past(vba_r) + {core_irq_vector, 1'b0}))
        else $error("vector address is not base plus twice vector");

    chk_no_reserved: assert property (
        @(posedge clk) disable iff (!resetn)
        core_irq_valid |-> !RESV_MASK[core_irq_vector])
        else $error("reserved or reset entry presented");

    chk_base_reset: assert property (
        @(posedge clk) disable iff (!resetn)
        first_r |-> vba_r == VBA_RST && core_vector_addr == VBA_RST)
        else $error("vector base not zero after reset");

    chk_lowest_last: assert property (
        @(posedge clk) disable iff (!resetn)
        (core_irq_valid && core_irq_vector == VEC_LOWEST) |->
            ($past(live) & ~(64'h1 << VEC_LOWEST)) == 64'h0 &&
            core_irq_level == RANK_W'(RANK_LP - RANK_OFS))
        else $error("lowest soft interrupt taken over another");

    chk_fixed_core: assert property (
        @(posedge clk) disable iff (!resetn)
        lv.rank[2] == lvl_to_rank(2'h3) && lv.rank[3] == lv.rank[2] &&
        lv.rank[4] == lv.rank[2] && lv.rank[5] == lv.rank[2])
        else $error("core exception not at level 3");

    chk_fixed_soft: assert property (
        @(posedge clk) disable iff (!resetn)
        lv.rank[11] == lvl_to_rank(2'h2) &&
        lv.rank[12] == lvl_to_rank(2'h1) &&
        lv.rank[13] == lvl_to_rank(2'h0))
        else $error("soft interrupt 2/1/0 level wrong");

    chk_hi_reject: assert property (
        @(posedge clk) disable iff (!resetn)
        (lv.wr_en && vec_class(lv.wr_vec) == CLS_HI &&
         lv.wr_lvl == LVL_MIN) |=>
            lv.wr_reject &&
            lv.rank[$past(lv.wr_vec)] == $past(lv.rank[lv.wr_vec]))
        else $error("level 0 accepted by a 1-3 source");

    chk_lo_reject: assert property (
        @(posedge clk) disable iff (!resetn)
        (lv.wr_en && vec_class(lv.wr_vec) == CLS_LO &&
         lv.wr_lvl == LVL_MAX) |=>
            lv.wr_reject &&
            lv.rank[$past(lv.wr_vec)] == $past(lv.rank[lv.wr_vec]))
        else $error("level 3 accepted by a 0-2 source");

    chk_level_write: assert property (
        @(posedge clk) disable iff (!resetn)
        (lv.wr_en && ((vec_class(lv.wr_vec) == CLS_HI &&
          lv.wr_lvl != LVL_MIN) || (vec_class(lv.wr_vec) == CLS_LO &&
          lv.wr_lvl != LVL_MAX))) |=>
            !lv.wr_reject &&
            lv.rank[$past(lv.wr_vec)] == lvl_to_rank($past(lv.wr_lvl)))
        else $error("legal level write not stored");

    chk_sticky_set: assert property (
        @(posedge clk) disable iff (!resetn)
        (core_irq_ack && core_irq_valid) |=> sts_r[ST_TAKEN])
        else $error("taken event lost");

    cov_level3_win: cover property (
        @(posedge clk) disable iff (!resetn)
        core_irq_valid && core_irq_level == 3'h3);

    cov_tie: cover property (
        @(posedge clk) disable iff (!resetn)
        ctrl_en_r && live[20] && live[21] &&
        lv.rank[20] == lv.rank[21]);

    cov_lowest: cover property (
        @(posedge clk) disable iff (!resetn)
        core_irq_valid && core_irq_vector == VEC_LOWEST);

    cov_reject: cover property (
        @(posedge clk) disable iff (!resetn)
        lv.wr_reject ##1 irq);

endmodule : vectored_priority_interrupt_map

// ---- test/core_model.sv ----
module core_model (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // presented vector
    input wire logic valid,
    input wire logic [vpim_pkg::VEC_W-1:0] vector,
    input wire logic [1:0] ack_delay,
    // answer to the controller
    output logic ack
);
    import vpim_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic [1:0] wait_r;
    logic done_r;
    logic [VEC_W-1:0] seen_r;

    // ****************************************
    // core acceptance
    // ****************************************
    // one ack per presentation; a new vector restarts the stall
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ack <= 1'b0;
            wait_r <= 2'h0;
            done_r <= 1'b0;
            seen_r <= '0;
        end
        else
        begin
            ack <= 1'b0;
            seen_r <= vector;
            if (valid !== 1'b1 || vector !== seen_r)
            begin
                wait_r <= 2'h0;
                done_r <= 1'b0;
            end
            else if (!done_r && wait_r >= ack_delay)
            begin
                ack <= 1'b1;
                done_r <= 1'b1;
            end
            else if (!done_r)
                wait_r <= wait_r + 2'h1;
        end
    end
endmodule : core_model

// ---- test/vectored_priority_interrupt_map_tb.sv ----
module vectored_priority_interrupt_map_tb;
    import vpim_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [63:0] irq_req = '0;
    logic core_irq_valid;
    logic [5:0] core_irq_vector;
    logic [2:0] core_irq_level;
    logic [20:0] core_vector_addr;
    logic core_irq_ack;
    logic irq;
    logic [1:0] ack_delay = 2'h0;
    logic [20:0] vector_table_base = '0;
    logic pv = 1'b0;
    logic [5:0] pvec = '0;
    logic [32:0] rd_q[$];
    logic [29:0] core_q[$];
    int error_cnt = 0;
    int compares = 0;
    int seed = 48;

    always #5 clk = ~clk;

    vectored_priority_interrupt_map dut (.clk(clk), .resetn(resetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_req(irq_req),
        .core_irq_valid(core_irq_valid), .core_irq_vector(core_irq_vector),
        .core_irq_level(core_irq_level),
        .core_vector_addr(core_vector_addr), .core_irq_ack(core_irq_ack),
        .irq(irq));

    core_model core (.clk(clk), .resetn(resetn), .valid(core_irq_valid),
        .vector(core_irq_vector), .ack_delay(ack_delay), .ack(core_irq_ack));

    // ****************************************
    // compare and report
    // ****************************************
    task automatic cmp(input string what, input logic [32:0] e,
        input logic [32:0] g);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : cmp

    task automatic conclude;
        cmp("leftover notes", 33'h0, 33'(rd_q.size() + core_q.size()));
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    // ****************************************
    // drivers
    // ****************************************
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
        input logic err = 1'b0);
        rd_q.push_back({err, e});
        apb(1'b0, a, 32'h0);
    endtask : rd

    function automatic logic [11:0] lvl_addr(input logic [5:0] v);
        return LVL_TBL_OFS + {4'h0, v, 2'b00};
    endfunction : lvl_addr

    // requests that must not reach the core under the current enable
    task automatic quiet(input logic [63:0] r);
        irq_req <= r;
        repeat (4) @(posedge clk);
        compares++;
        if (core_irq_valid !== 1'b0)
        begin
            error_cnt++;
            $display("wrong value core_irq_valid expected 0 seen %b",
                core_irq_valid);
        end
        irq_req <= '0;
        repeat (2) @(posedge clk);
    endtask : quiet

    task automatic present(input logic [63:0] r, input logic [5:0] v,
        input logic [2:0] l);
        int n;
        core_q.push_back({v, l, 21'(vector_table_base + 21'({v, 1'b0}))});
        irq_req <= r;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (core_irq_valid !== 1'b1 && n < 20);
        repeat (5) @(posedge clk);
        irq_req <= '0;
        repeat (3) @(posedge clk);
    endtask : present

    // ****************************************
    // result watchers
    // ****************************************
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            cmp("apb read", rd_q.size() ? rd_q.pop_front() : 33'h0,
                {pslverr, prdata});
        pv <= core_irq_valid;
        pvec <= core_irq_vector;
        if (resetn && core_irq_valid === 1'b1 &&
            (!pv || core_irq_vector !== pvec))
            cmp("core vector", core_q.size() ? 33'(core_q.pop_front()) : '1,
                33'({core_irq_vector, core_irq_level, core_vector_addr}));
    end

    task automatic cmp_irq(input logic e);
        repeat (2) @(posedge clk);
        cmp("irq", 33'(e), 33'(irq));
    endtask : cmp_irq

    initial
    begin
        #200us;
        error_cnt++;
        conclude();
    end

    // ****************************************
    // scenarios
    // ****************************************
    logic [5:0] rs_v [7] = '{6'h06, 6'h14, 6'h02, 6'h0B, 6'h0C, 6'h0D, 6'h3F};
    logic [2:0] rs_l [7] = '{3'h1, 3'h0, 3'h3, 3'h2, 3'h1, 3'h0, 3'h7};
    logic [5:0] lw_v [8] = '{6'h14, 6'h06, 6'h02, 6'h0F, 6'h11, 6'h14,
        6'h28, 6'h10};
    logic [1:0] lw_l [8] = '{2'h3, 2'h0, 2'h1, 2'h3, 2'h2, 2'h2, 2'h2, 2'h1};
    logic [2:0] lw_e [8] = '{3'h0, 3'h1, 3'h3, 3'h3, 3'h2, 3'h2, 3'h2, 3'h1};
    logic [63:0] pr_r [7] = '{64'h0000_0000_0012_0000,
        64'h0000_0000_0000_8800, 64'h0000_0100_0020_0000,
        64'h8000_0000_0000_2000, 64'h8000_0000_0000_0000,
        64'h0000_0000_0000_8020, 64'h0000_0000_0020_1000};
    logic [5:0] pr_v [7] = '{6'h11, 6'h0F, 6'h28, 6'h0D, 6'h3F, 6'h05, 6'h0C};
    logic [2:0] pr_l [7] = '{3'h2, 3'h3, 3'h2, 3'h0, 3'h7, 3'h3, 3'h1};

    initial
    begin
        logic [5:0] rv;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rd(VBA_OFS, 32'h0);
        rd(CTRL_OFS, 32'h0);
        rd(STAT_OFS, 32'h0);
        rd(MASK_OFS, 32'h0);
        for (int i = 0; i < 7; i++)
            rd(lvl_addr(rs_v[i]), 32'(rs_l[i]));
        rd(12'h020, 32'h0, 1'b1);
        quiet(64'h0000_0000_0010_0000);
        apb(1'b1, CTRL_OFS, 32'h1);
        quiet(64'h001E_00F0_C000_4003);
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, lvl_addr(lw_v[i]), 32'(lw_l[i]));
            rd(lvl_addr(lw_v[i]), 32'(lw_e[i]));
        end
        rd(STAT_OFS, 32'h2);
        apb(1'b1, STAT_OFS, 32'h7);
        rd(STAT_OFS, 32'h0);
        for (int i = 0; i < 7; i++)
        begin
            ack_delay <= 2'(i);
            present(pr_r[i], pr_v[i], pr_l[i]);
        end
        vector_table_base = 21'($random(seed));
        apb(1'b1, VBA_OFS, 32'(vector_table_base));
        rd(VBA_OFS, 32'(vector_table_base));
        rv = 6'h16 + 6'(unsigned'($random(seed)) % 8);
        present(64'h1 << rv, rv, 3'h0);
        rd(STAT_OFS, 32'h5);
        apb(1'b1, MASK_OFS, 32'h4);
        cmp_irq(1'b1);
        apb(1'b1, MASK_OFS, 32'h0);
        cmp_irq(1'b0);
        apb(1'b1, MASK_OFS, 32'h1);
        cmp_irq(1'b1);
        apb(1'b1, STAT_OFS, 32'h7);
        cmp_irq(1'b0);
        rd(STAT_OFS, 32'h0);
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule : vectored_priority_interrupt_map_tb
